//--- pacc_defines.svh
`ifndef PACC_DEFINES_SVH
`define PACC_DEFINES_SVH

// Register byte addresses (word aligned, Wishbone)
`define PACC_ADDR_CTRL      8'h20
`define PACC_ADDR_COUNT     8'h24
`define PACC_ADDR_STATUS    8'h28
`define PACC_ADDR_MASK      8'h2c
`define PACC_ADDR_CLKSRC    8'h30

// Control register fields
`define PACC_BIT_ENABLE     6
`define PACC_BIT_MODE       5
`define PACC_BIT_EDGE       4
`define PACC_CLK_HI         3
`define PACC_CLK_LO         2
`define PACC_BIT_OVF_IE     1
`define PACC_BIT_INP_IE     0
`define PACC_CTRL_WMASK     8'h7f
`define PACC_CTRL_RESET     8'h00

// Status and mask fields
`define PACC_ST_OVF         1
`define PACC_ST_INP         0
`define PACC_ST_RESET       2'h0
`define PACC_MASK_RESET     2'h3

// Gated mode prescaler: bus clock divided by 64
`define PACC_DIV_LAST       6'h3f
`define PACC_COUNT_RESET    16'h0000
`define PACC_COUNT_MAX      16'hffff
`define PACC_COUNT_ONE      16'h0001

`endif

//--- pacc_pkg.sv
package pacc_pkg;
   // Operating mode of the accumulator
   typedef enum logic [1:0] {
      PACC_OFF,
      PACC_EVENT,
      PACC_GATED
   } pacc_mode_t;

   // Whole state of the block
   typedef struct packed {
      logic [7:0]  ctrl;
      logic [15:0] count;
      logic [1:0]  status;
      logic [1:0]  mask;
      logic [5:0]  div;
      logic        pin_s1;
      logic        pin_s2;
      logic        pin_prev;
      logic        ack;
      logic [31:0] rdata;
      pacc_mode_t  mode;
   } pacc_state_t;
endpackage

//--- pacc_top.sv
// The Wishbone slave port was decided locally.
`timescale 1ns/1ps
`include "pacc_defines.svh"

module pacc_top
   import pacc_pkg::*;
(
   input  wire logic        CLK,           // Bus clock, 50 MHz
   input  wire logic        RSTN,          // Synchronous reset, active low
   input  wire logic        WB_CYC_I,      // Wishbone cycle
   input  wire logic        WB_STB_I,      // Wishbone strobe
   input  wire logic        WB_WE_I,       // Wishbone write enable
   input  wire logic [7:0]  WB_ADR_I,      // Wishbone byte address
   input  wire logic [3:0]  WB_SEL_I,      // Wishbone byte selects
   input  wire logic [31:0] WB_DAT_I,      // Wishbone write data
   output logic      [31:0] WB_DAT_O,      // Wishbone read data
   output logic             WB_ACK_O,      // Wishbone acknowledge
   input  wire logic        CHANNEL_SEVEN_PIN, // Shared channel seven input pin
   input  wire logic        TIMER_ENABLE,  // Main timer enable, not used by accumulator
   output logic [1:0]       TIMER_CLK_SEL, // Timer clock-select field
   output logic             IRQ            // Level interrupt request
);

   pacc_state_t q, d;

   // Bus decode, pin qualifiers and count path
   logic        req;
   logic        wr_ctrl;
   logic        wr_count;
   logic        wr_status;
   logic        wr_mask;
   logic        enabled;
   logic        gate_open;
   logic        edge_hit;
   logic        trail_hit;
   logic        tick;
   logic        wrap;
   logic        pin_rise;
   logic        pin_fall;
   logic [15:0] count_next;
   logic [1:0]  set_bits;

   // Address match helper, used by every write-strobe decode
   function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_addr);
      return a == reg_addr;
   endfunction

   // Byte lane 0 merge for an 8-bit register
   function automatic logic [7:0] lane0(input logic [7:0] old, input logic [31:0] wd,
                                        input logic [3:0] sel);
      return sel[0] ? wd[7:0] : old;
   endfunction

   // Polarity pick shared by edge, gate and trailing-edge decode
   function automatic logic pol_sel(input logic rising_sel,
                                    input logic when_one,
                                    input logic when_zero);
      logic pick;
      if (rising_sel) begin
         pick = when_one;
      end else begin
         pick = when_zero;
      end
      return pick;
   endfunction

   // Write strobe for one register address
   function automatic logic wr_hit(input logic       take,
                                   input logic       we,
                                   input logic [7:0] a,
                                   input logic [7:0] reg_addr);
      return take && we && hit(a, reg_addr);
   endfunction

   // Mode decode; edge and mode bits count for nothing when disabled
   function automatic pacc_mode_t mode_of(input logic en,
                                          input logic gated);
      pacc_mode_t m;
      if (!en) begin
         m = PACC_OFF;
      end else if (gated) begin
         m = PACC_GATED;
      end else begin
         m = PACC_EVENT;
      end
      return m;
   endfunction

   // Divide-by-64 step; holds while the gate is closed
   function automatic logic [6:0] prescale(input logic [5:0] div,
                                           input logic       run);
      logic [6:0] res;
      res = {1'b0, div};
      if (run) begin
         res[5:0] = div + 6'h01;
         res[6]   = (div == `PACC_DIV_LAST);
      end
      return res;
   endfunction

   // Count step: next value and the wrap that sets the overflow flag
   function automatic logic [16:0] count_step(input logic [15:0] count,
                                              input logic        inc);
      logic [16:0] res;
      res = {1'b0, count};
      if (inc) begin
         res[15:0] = count + `PACC_COUNT_ONE;
         res[16]   = (count == `PACC_COUNT_MAX);
      end
      return res;
   endfunction

   // Byte-lane merge of the 16-bit count; lanes 0 and 1 only
   function automatic logic [15:0] lane01(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  sel);
      logic [15:0] merged;
      merged = old;
      if (sel[0]) begin
         merged[7:0] = wd[7:0];
      end
      if (sel[1]) begin
         merged[15:8] = wd[15:8];
      end
      return merged;
   endfunction

   // Sticky flags: write one clears, a same-cycle event still sets
   function automatic logic [1:0] sticky(input logic [1:0] old,
                                         input logic [1:0] wd,
                                         input logic       clr_en,
                                         input logic [1:0] set);
      logic [1:0] kept;
      kept = old;
      if (clr_en) begin
         kept = old & ~wd;
      end
      return kept | set;
   endfunction

   // Read data for one address; holes read zero
   function automatic logic [31:0] read_word(input logic [7:0]  a,
                                             input logic [7:0]  ctrl,
                                             input logic [15:0] count,
                                             input logic [1:0]  status,
                                             input logic [1:0]  mask);
      logic [31:0] word;
      word = '0;
      unique case (a)
         `PACC_ADDR_CTRL:   word = {24'h000000, ctrl};
         `PACC_ADDR_COUNT:  word = {16'h0000, count};
         `PACC_ADDR_STATUS: word = {30'h00000000, status};
         `PACC_ADDR_MASK:   word = {30'h00000000, mask};
         `PACC_ADDR_CLKSRC: word = {30'h00000000, ctrl[`PACC_CLK_HI:`PACC_CLK_LO]};
         default:           word = '0;
      endcase
      return word;
   endfunction

   // Whole-block reset image; bus, pin stages and flags all quiet
   function automatic pacc_state_t reset_state();
      pacc_state_t r;
      r.ctrl     = `PACC_CTRL_RESET;
      r.count    = `PACC_COUNT_RESET;
      r.status   = `PACC_ST_RESET;
      r.mask     = `PACC_MASK_RESET;
      r.div      = '0;
      r.pin_s1   = 1'b0;
      r.pin_s2   = 1'b0;
      r.pin_prev = 1'b0;
      r.ack      = 1'b0;
      r.rdata    = '0;
      r.mode     = PACC_OFF;
      return r;
   endfunction

   // Timer enable has no say over the accumulator
   logic unused_ten;
   assign unused_ten = TIMER_ENABLE;

   always_comb begin
      d = q;

      // Bus strobes; one-cycle ack, dropped the cycle after
      req       = WB_CYC_I && WB_STB_I && !q.ack;
      wr_ctrl   = wr_hit(req, WB_WE_I, WB_ADR_I, `PACC_ADDR_CTRL);
      wr_count  = wr_hit(req, WB_WE_I, WB_ADR_I, `PACC_ADDR_COUNT);
      wr_status = wr_hit(req, WB_WE_I, WB_ADR_I, `PACC_ADDR_STATUS);
      wr_mask   = wr_hit(req, WB_WE_I, WB_ADR_I, `PACC_ADDR_MASK);

      // Pin synchroniser: only the second stage and its delayed copy pin_prev are looked at
      d.pin_s1   = CHANNEL_SEVEN_PIN;
      d.pin_s2   = q.pin_s1;
      d.pin_prev = q.pin_s2;
      pin_rise   = q.pin_s2 && !q.pin_prev;
      pin_fall   = !q.pin_s2 && q.pin_prev;

      // Mode decode; edge and mode bits count for nothing when disabled
      enabled = q.ctrl[`PACC_BIT_ENABLE];
      d.mode  = mode_of(enabled, q.ctrl[`PACC_BIT_MODE]);

      // Event and gate qualifiers, per edge-control polarity
      edge_hit  = pol_sel(q.ctrl[`PACC_BIT_EDGE], pin_rise, pin_fall);
      gate_open = pol_sel(q.ctrl[`PACC_BIT_EDGE], !q.pin_s2, q.pin_s2);
      trail_hit = pol_sel(q.ctrl[`PACC_BIT_EDGE], pin_rise, pin_fall);

      // Divide-by-64 prescaler runs only while the gate is open
      {tick, d.div} = prescale(q.div,
                               q.mode == PACC_GATED && gate_open);
      if (q.mode != PACC_GATED) begin
         d.div = '0;
      end

      // Count increment source
      set_bits = 2'h0;
      wrap     = 1'b0;
      unique case (q.mode)
         PACC_EVENT: begin
            {wrap, d.count} = count_step(q.count, edge_hit);
         end
         PACC_GATED: begin
            {wrap, d.count} = count_step(q.count, tick);
            set_bits[`PACC_ST_INP] = trail_hit;
         end
         PACC_OFF: begin
            d.count = q.count;
         end
      endcase
      set_bits[`PACC_ST_OVF] = wrap;

      // Software write of the count wins over an increment
      count_next = d.count;
      if (wr_count) begin
         count_next = lane01(d.count, WB_DAT_I, WB_SEL_I);
      end
      d.count = count_next;

      // Control register writable any time; bit 7 held at zero
      if (wr_ctrl) begin
         d.ctrl = lane0(q.ctrl, WB_DAT_I, WB_SEL_I) & `PACC_CTRL_WMASK;
      end

      // Sticky flags: write one clears, a new event beats the clear
      d.status = sticky(q.status,
                        WB_DAT_I[1:0],
                        wr_status && WB_SEL_I[0],
                        set_bits);

      // Mask register, same layout as status
      if (wr_mask && WB_SEL_I[0]) begin
         d.mask = WB_DAT_I[1:0];
      end

      // Read mux, unmapped addresses read zero
      d.ack   = req;
      d.rdata = '0;
      if (req && !WB_WE_I) begin
         d.rdata = read_word(WB_ADR_I,
                             q.ctrl,
                             q.count,
                             q.status,
                             q.mask);
      end

      // Reset values
      if (!RSTN) begin
         d = reset_state();
      end
   end

   // Single register stage for the whole state
   always_ff @(posedge CLK) begin
      q <= d;
   end

   // Outputs
   assign WB_DAT_O      = q.rdata;
   assign WB_ACK_O      = q.ack;
   assign TIMER_CLK_SEL = q.ctrl[`PACC_CLK_HI:`PACC_CLK_LO];
   // Interrupt: flag and its enable bit, further gated by the mask register
   logic [1:0] src_flag;
   logic [1:0] src_en;
   logic [1:0] src_req;
   assign src_flag = q.status;
   assign src_en   = {q.ctrl[`PACC_BIT_OVF_IE], q.ctrl[`PACC_BIT_INP_IE]};
   genvar gi;
   generate
      for (gi = 0; gi < $bits(src_req); gi++) begin : g_irq
         assign src_req[gi] = src_flag[gi] && src_en[gi] && q.mask[gi];
      end
   endgenerate
   assign IRQ = |src_req;

endmodule // pacc_top

//--- pacc_top_properties.sv
`timescale 1ns/1ps
// Port-level checks of the bus slave and interrupt path
module pacc_checker (
   input wire logic        CLK,           // Bus clock
   input wire logic        RSTN,          // Sync reset, low
   input wire logic        WB_CYC_I,      // Cycle
   input wire logic        WB_STB_I,      // Strobe
   input wire logic        WB_WE_I,       // Write enable
   input wire logic [7:0]  WB_ADR_I,      // Address
   input wire logic [31:0] WB_DAT_O,      // Read data
   input wire logic        WB_ACK_O,      // Acknowledge
   input wire logic [1:0]  TIMER_CLK_SEL, // Clock select
   input wire logic        IRQ            // Interrupt
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RSTN);
   // Decoded bus events
   logic req, rd, wr_ctrl;
   assign req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
   assign rd = WB_ACK_O && !WB_WE_I;
   assign wr_ctrl = WB_CYC_I && WB_STB_I && WB_WE_I && WB_ADR_I == 8'h20;
   a_ack_next: assert property (req |=> WB_ACK_O) else $error("no ack");
   a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack held");
   a_ack_cause: assert property ($rose(WB_ACK_O) |-> $past(req)) else $error("stray ack");
   a_rdata_idle: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0) else $error("data");
   a_ctrl_bit7: assert property (rd && WB_ADR_I == 8'h20 |-> WB_DAT_O[31:7] == 25'h0)
      else $error("ctrl high bits");
   a_clksel_read: assert property (rd && WB_ADR_I == 8'h30 |-> WB_DAT_O == {30'h0, TIMER_CLK_SEL})
      else $error("clksel read");
   a_clksel_write: assert property ($changed(TIMER_CLK_SEL) |-> $past(wr_ctrl) || $past(wr_ctrl, 2))
      else $error("clksel moved");
   a_irq_fall: assert property ($fell(IRQ) |-> $past(WB_CYC_I && WB_WE_I, 1)
      || $past(WB_CYC_I && WB_WE_I, 2)) else $error("irq fell");
endmodule // pacc_checker
bind pacc_top pacc_checker chk_i (.CLK(CLK), .RSTN(RSTN), .WB_CYC_I(WB_CYC_I),
   .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_O(WB_DAT_O),
   .WB_ACK_O(WB_ACK_O), .TIMER_CLK_SEL(TIMER_CLK_SEL), .IRQ(IRQ));

//--- pacc_pin_model.sv
`timescale 1ns/1ps
// External pulse or gate source on the shared pin
module pacc_pin_model (
   input  wire logic clk, // Bus clock
   output logic      pin  // Pin level
);
   initial pin = 1'b0;
   // Level set just after an edge, then held
   task automatic drive(input logic v, input int hold);
      @(posedge clk);
      pin <= v;
      repeat (hold) @(posedge clk);
   endtask
endmodule // pacc_pin_model

//--- test_pulse_accumulator_control.sv
`timescale 1ns/1ps
`include "pacc_defines.svh"
module test_pulse_accumulator_control;
   logic        CLK, RSTN, cyc, stb, we, pin, ack, irq;
   logic [7:0]  adr;
   logic [31:0] wdat, rd, dat_o;
   logic [1:0]  csel;
   int          mismatches, n_checks;
   pacc_pin_model src (.clk(CLK), .pin(pin));
   pacc_top uut (.CLK(CLK), .RSTN(RSTN), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
      .WB_ADR_I(adr), .WB_SEL_I(4'h3), .WB_DAT_I(wdat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
      .CHANNEL_SEVEN_PIN(pin), .TIMER_ENABLE(1'b0), .TIMER_CLK_SEL(csel), .IRQ(irq));
   initial begin
      CLK = 1'b0;
      forever #10 CLK = ~CLK;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // One classic cycle; only the watchdog ends a wait for ack
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge CLK);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
      do begin
         @(posedge CLK);
      end while (ack !== 1'b1);
      rd = dat_o;
      cyc <= 1'b0; stb <= 1'b0;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask
   task automatic t_ctrl;
      rdchk(`PACC_ADDR_CTRL, 32'h0);
      rdchk(`PACC_ADDR_STATUS, 32'h0);
      wb(1'b1, `PACC_ADDR_CTRL, 32'hff);
      rdchk(`PACC_ADDR_CTRL, 32'h7f);
      chk({30'h0, csel}, 32'h3);
      rdchk(`PACC_ADDR_CLKSRC, 32'h3);
      rdchk(8'h00, 32'h0);
   endtask
   // Disabled pulse ignored, then one edge of each polarity, timer off
   task automatic t_event;
      for (int e = 0; e < 2; e++) begin
         wb(1'b1, `PACC_ADDR_CTRL, e ? 32'h10 : 32'h20);
         wb(1'b1, `PACC_ADDR_COUNT, 32'h0);
         src.drive(1'b1, 6);
         src.drive(1'b0, 6);
         rdchk(`PACC_ADDR_COUNT, 32'h0);
         wb(1'b1, `PACC_ADDR_CTRL, e ? 32'h50 : 32'h40);
         src.drive(1'b1, 6);
         rdchk(`PACC_ADDR_COUNT, e);
         src.drive(1'b0, 6);
         rdchk(`PACC_ADDR_COUNT, 32'h1);
      end
   endtask
   task automatic t_ovf;
      wb(1'b1, `PACC_ADDR_CTRL, 32'h42);
      wb(1'b1, `PACC_ADDR_COUNT, 32'hffff);
      src.drive(1'b1, 6);
      src.drive(1'b0, 6);
      rdchk(`PACC_ADDR_COUNT, 32'h0);
      chk(irq, 1'b1);
      wb(1'b1, `PACC_ADDR_CTRL, 32'h40);
      rdchk(`PACC_ADDR_STATUS, 32'h2);
      chk(irq, 1'b0);
      wb(1'b1, `PACC_ADDR_STATUS, 32'h2);
      rdchk(`PACC_ADDR_STATUS, 32'h0);
   endtask
   // Gate open 200 cycles gives three ticks of the divide-by-64
   task automatic t_gated;
      for (int e = 0; e < 2; e++) begin
         wb(1'b1, `PACC_ADDR_CTRL, 32'h0);
         src.drive(e[0], 4);
         wb(1'b1, `PACC_ADDR_COUNT, 32'h0);
         wb(1'b1, `PACC_ADDR_STATUS, 32'h3);
         rdchk(`PACC_ADDR_STATUS, 32'h0);
         wb(1'b1, `PACC_ADDR_CTRL, e ? 32'h71 : 32'h61);
         src.drive(!e[0], 200);
         src.drive(e[0], 6);
         rdchk(`PACC_ADDR_COUNT, 32'h3);
         rdchk(`PACC_ADDR_STATUS, 32'h1);
         chk(irq, 1'b1);
         wb(1'b1, `PACC_ADDR_MASK, 32'h0);
         rdchk(`PACC_ADDR_MASK, 32'h0);
         chk(irq, 1'b0);
         wb(1'b1, `PACC_ADDR_MASK, 32'h3);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Watchdog well past the several hundred cycles needed
   initial begin
      #300us;
      mismatches++;
      tally_and_finish;
   end
   initial begin
      RSTN = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h0; wdat = 32'h0;
      mismatches = 0; n_checks = 0;
      repeat (12) @(posedge CLK);
      RSTN <= 1'b1;
      t_ctrl;
      t_event;
      t_ovf;
      t_gated;
      tally_and_finish;
   end
endmodule // test_pulse_accumulator_control
